/* File: hdl/pulse_interval.sv */
module pulse_interval #(
	parameter int unsigned MS_CYCLES = 40000
)(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic pulse,
	input wire logic [23:0] time_a,
	input wire logic [23:0] time_b,
	output logic a_over,
	output logic b_over
);
	logic [31:0] div_reg, div_next;
	logic [23:0] ms_reg, ms_next;

	// Millisecond count since the last sensor pulse, saturating
	always_comb begin
		div_next = div_reg + 32'h1;
		ms_next = ms_reg;
		if (div_reg >= MS_CYCLES - 1) begin
			div_next = 32'h0;
			if (ms_reg != 24'hffffff)
				ms_next = ms_reg + 24'h1;
		end
		if (pulse) begin
			div_next = 32'h0;
			ms_next = 24'h0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			div_reg <= 32'h0;
			ms_reg <= 24'h0;
		end else begin
			div_reg <= div_next;
			ms_reg <= ms_next;
		end
	end

	// Single interval compared, never an average
	assign a_over = ms_reg > time_a;
	assign b_over = ms_reg > time_b;
endmodule : pulse_interval

/* File: hdl/tacho_diag_defs.svh */
`ifndef TACHO_DIAG_DEFS_SVH
`define TACHO_DIAG_DEFS_SVH

// Register byte offsets
`define ADDR_CTRL 8'h00
`define ADDR_TIME_A 8'h04
`define ADDR_TIME_B 8'h08
`define ADDR_STARTUP 8'h0c
`define ADDR_RUN_ALARM 8'h10
`define ADDR_ON_ALARM 8'h14
`define ADDR_AVG 8'h18
`define ADDR_STATUS 8'h1c
`define ADDR_IRQ_STAT 8'h20
`define ADDR_IRQ_MASK 8'h24
`define ADDR_RUN_MON 8'h28
`define ADDR_ON_MON 8'h2c
`define ADDR_MEAS 8'h30
// Field positions
`define CTRL_MODE_LSB 0
`define CTRL_HOLD_BIT 2
// Factory values
`define TIME_A_RST 24'h0003e8
`define TIME_B_RST 24'h002710
`define STARTUP_RST 10'h000
`define RUN_ALARM_RST 10'h064
`define ON_ALARM_RST 14'h0064
`define AVG_RST 4'h1
`define MODE_RST 2'h0
`define MEAS_MAX 20'hf423f
`define SETTING_MAX 10'h3e7
`define ON_SUB_MAX 10'h3e7
// Timing
`define CLK_PERIOD_NS 25
`define TENTH_SEC_MS 100
`define TENTH_SEC_CYCLES (`TENTH_SEC_MS * 1000000 / `CLK_PERIOD_NS)
`define MS_CYCLES (1000000 / `CLK_PERIOD_NS)
`define TENTH_YEAR_SEC 3155760
`define BLINK_HALF_TENTHS 3'h4
`define TENTHS_PER_SEC 4'h9
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

/* File: hdl/tacho_diag_pkg.sv */
package tacho_diag_pkg;
	typedef enum logic [3:0] {
		F_NONE = 4'h1,
		F_CPU = 4'h2,
		F_RAM = 4'h4,
		F_NVM = 4'h8
	} fault_t;
	typedef enum logic [2:0] {
		MD_VALUE = 3'h0,
		MD_OVERFLOW = 3'h1,
		MD_BLANK = 3'h2,
		MD_CPU = 3'h3,
		MD_MEMORY = 3'h4,
		MD_REPLACE = 3'h5
	} main_disp_t;
	typedef enum logic [1:0] {
		SD_NORMAL = 2'h0,
		SD_BLANK = 2'h1,
		SD_CHECKSUM = 2'h2
	} sub_disp_t;
	typedef enum logic [1:0] {
		OM_LIMITS = 2'h0,
		OM_UPPER_LOWER = 2'h1
	} out_mode_t;
endpackage : tacho_diag_pkg

/* File: hdl/tacho_self_diag_hold.sv */
// Added by the designer: the AXI4-Lite slave port and the address map.
`include "tacho_diag_defs.svh"
module tacho_self_diag_hold #(
	parameter int unsigned TENTH_SEC_CYCLES = `TENTH_SEC_CYCLES,
	parameter int unsigned MS_CYCLES = `MS_CYCLES,
	parameter int unsigned TENTH_YEAR_SEC = `TENTH_YEAR_SEC
)(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [7:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	input wire logic [7:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	input wire logic pulse_tick,
	input wire logic hold_in,
	input wire logic hold_key,
	input wire logic [19:0] meas_value,
	input wire logic cpu_fault,
	input wire logic ram_fault,
	input wire logic nvm_fault,
	output logic out_on,
	output logic [2:0] main_disp,
	output logic [1:0] sub_disp,
	output logic [19:0] disp_value,
	output logic irq
);
	////////////////////////////////////////////////////////////////////////
	// Bus channel state
	logic aw_have_reg, aw_have_next, w_have_reg, w_have_next;
	logic [7:0] waddr_reg, waddr_next;
	logic [31:0] wdat_reg, wdat_next;
	logic [3:0] wstb_reg, wstb_next;
	logic bvalid_reg, bvalid_next, rvalid_reg, rvalid_next;
	logic [1:0] bresp_reg, bresp_next, rresp_reg, rresp_next;
	logic [31:0] rdata_reg, rdata_next;
	logic wr_go, wr_hit, rd_hit;
	logic [31:0] rd_word;

	// Settings and core state
	logic [1:0] mode_reg, mode_next;
	logic [23:0] ta_reg, ta_next, tb_reg, tb_next;
	logic [9:0] stup_reg, stup_next, ralm_reg, ralm_next;
	logic [13:0] oalm_reg, oalm_next;
	logic [3:0] avg_reg, avg_next;
	logic [4:0] ist_reg, ist_next, imask_reg, imask_next;
	tacho_diag_pkg::fault_t fault_reg, fault_next;
	logic [31:0] tcnt_reg, tcnt_next, ysec_reg, ysec_next;
	logic [2:0] bcnt_reg, bcnt_next;
	logic [3:0] scnt_reg, scnt_next;
	logic blink_reg, blink_next, started_reg, started_next;
	logic [9:0] scount_reg, scount_next, run_reg, run_next;
	logic [9:0] onsub_reg, onsub_next;
	logic [13:0] onk_reg, onk_next;
	logic rpl_clr_reg, rpl_clr_next, out_reg, out_next;
	logic ovf_prev_reg, rpl_prev_reg;
	logic [2:0] md_reg, md_next;
	logic [1:0] sd_reg, sd_next;
	logic [19:0] dv_reg, dv_next;
	logic tenth_tick, hold_op, ovf, rpl_hit, rpl_show, a_over, b_over;
	logic [4:0] events;

	function automatic logic [31:0] merge(input logic [31:0] old,
		input logic [31:0] nw, input logic [3:0] stb);
		logic [31:0] m;
		m = {{8{stb[3]}}, {8{stb[2]}}, {8{stb[1]}}, {8{stb[0]}}};
		return (old & ~m) | (nw & m);
	endfunction : merge

	////////////////////////////////////////////////////////////////////////
	// Write channels taken in either order; one write, one read at a time
	assign awready = !aw_have_reg && !bvalid_reg;
	assign wready = !w_have_reg && !bvalid_reg;
	assign arready = !rvalid_reg;
	assign wr_go = aw_have_reg && w_have_reg;
	assign wr_hit = waddr_reg[7:2] <= 6'hc && waddr_reg[7:2] != 6'h7;
	assign rd_hit = araddr[7:2] <= 6'hc;

	// Read data multiplexer
	always_comb begin
		rd_word = 32'h0;
		unique case (araddr[7:2])
		6'h0: rd_word = {30'h0, mode_reg};
		6'h1: rd_word = {8'h0, ta_reg};
		6'h2: rd_word = {8'h0, tb_reg};
		6'h3: rd_word = {22'h0, stup_reg};
		6'h4: rd_word = {22'h0, ralm_reg};
		6'h5: rd_word = {18'h0, oalm_reg};
		6'h6: rd_word = {28'h0, avg_reg};
		6'h7: rd_word = {23'h0, hold_in, started_reg, out_reg, rpl_show,
			ovf, fault_reg};
		6'h8: rd_word = {27'h0, ist_reg};
		6'h9: rd_word = {27'h0, imask_reg};
		6'ha: rd_word = {22'h0, run_reg};
		6'hb: rd_word = {18'h0, onk_reg};
		6'hc: rd_word = {12'h0, dv_reg};
		default: rd_word = 32'h0;
		endcase
	end

	// Bus handshake next state
	always_comb begin
		aw_have_next = aw_have_reg;
		w_have_next = w_have_reg;
		waddr_next = waddr_reg;
		wdat_next = wdat_reg;
		wstb_next = wstb_reg;
		bvalid_next = bvalid_reg && !bready;
		bresp_next = bresp_reg;
		rvalid_next = rvalid_reg && !rready;
		rresp_next = rresp_reg;
		rdata_next = rdata_reg;
		if (awvalid && awready) begin
			aw_have_next = 1'b1;
			waddr_next = awaddr;
		end
		if (wvalid && wready) begin
			w_have_next = 1'b1;
			wdat_next = wdata;
			wstb_next = wstrb;
		end
		if (wr_go) begin
			aw_have_next = 1'b0;
			w_have_next = 1'b0;
			bvalid_next = 1'b1;
			bresp_next = wr_hit ? `RESP_OKAY : `RESP_SLVERR;
		end
		if (arvalid && arready) begin
			rvalid_next = 1'b1;
			rdata_next = rd_word;
			rresp_next = rd_hit ? `RESP_OKAY : `RESP_SLVERR;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_have_reg <= 1'b0;
			w_have_reg <= 1'b0;
			waddr_reg <= 8'h0;
			wdat_reg <= 32'h0;
			wstb_reg <= 4'h0;
			bvalid_reg <= 1'b0;
			bresp_reg <= 2'h0;
			rvalid_reg <= 1'b0;
			rresp_reg <= 2'h0;
			rdata_reg <= 32'h0;
		end else begin
			aw_have_reg <= aw_have_next;
			w_have_reg <= w_have_next;
			waddr_reg <= waddr_next;
			wdat_reg <= wdat_next;
			wstb_reg <= wstb_next;
			bvalid_reg <= bvalid_next;
			bresp_reg <= bresp_next;
			rvalid_reg <= rvalid_next;
			rresp_reg <= rresp_next;
			rdata_reg <= rdata_next;
		end
	end

	assign bvalid = bvalid_reg;
	assign bresp = bresp_reg;
	assign rvalid = rvalid_reg;
	assign rresp = rresp_reg;
	assign rdata = rdata_reg;

	////////////////////////////////////////////////////////////////////////
	// Hold operation from the key or from a control write
	logic [31:0] ctrl_w;
	assign ctrl_w = merge(32'h0, wdat_reg, wstb_reg);
	assign hold_op = hold_key ||
		(wr_go && waddr_reg == `ADDR_CTRL && ctrl_w[`CTRL_HOLD_BIT]);
	assign ovf = meas_value > `MEAS_MAX;
	assign rpl_hit = (ralm_reg != 10'h0 && run_reg >= ralm_reg) ||
		(oalm_reg != 14'h0 && onk_reg >= oalm_reg);
	assign rpl_show = rpl_hit && !rpl_clr_reg;
	assign tenth_tick = tcnt_reg >= TENTH_SEC_CYCLES - 1;
	assign events = {rpl_show && !rpl_prev_reg,
		nvm_fault, ram_fault, cpu_fault, ovf && !ovf_prev_reg};

	// Settings; a cleared non-volatile fault reloads factory values
	always_comb begin
		logic [31:0] m;
		m = 32'h0;
		mode_next = mode_reg;
		ta_next = ta_reg;
		tb_next = tb_reg;
		stup_next = stup_reg;
		ralm_next = ralm_reg;
		oalm_next = oalm_reg;
		avg_next = avg_reg;
		imask_next = imask_reg;
		if (wr_go) begin
			unique case (waddr_reg)
			`ADDR_CTRL: begin
				m = merge({30'h0, mode_reg}, wdat_reg, wstb_reg);
				mode_next = m[`CTRL_MODE_LSB +: 2];
			end
			`ADDR_TIME_A: begin
				m = merge({8'h0, ta_reg}, wdat_reg, wstb_reg);
				ta_next = m[23:0];
			end
			`ADDR_TIME_B: begin
				m = merge({8'h0, tb_reg}, wdat_reg, wstb_reg);
				tb_next = m[23:0];
			end
			`ADDR_STARTUP: begin
				m = merge({22'h0, stup_reg}, wdat_reg, wstb_reg);
				if (m[9:0] <= `SETTING_MAX)
					stup_next = m[9:0];
			end
			`ADDR_RUN_ALARM: begin
				m = merge({22'h0, ralm_reg}, wdat_reg, wstb_reg);
				if (m[9:0] <= `SETTING_MAX)
					ralm_next = m[9:0];
			end
			`ADDR_ON_ALARM: begin
				m = merge({18'h0, oalm_reg}, wdat_reg, wstb_reg);
				oalm_next = m[13:0];
			end
			`ADDR_AVG: begin
				m = merge({28'h0, avg_reg}, wdat_reg, wstb_reg);
				avg_next = m[3:0];
			end
			`ADDR_IRQ_MASK: begin
				m = merge({27'h0, imask_reg}, wdat_reg, wstb_reg);
				imask_next = m[4:0];
			end
			default: m = 32'h0;
			endcase
		end
		if (hold_op && fault_reg == tacho_diag_pkg::F_NVM) begin
			mode_next = `MODE_RST;
			ta_next = `TIME_A_RST;
			tb_next = `TIME_B_RST;
			stup_next = `STARTUP_RST;
			ralm_next = `RUN_ALARM_RST;
			oalm_next = `ON_ALARM_RST;
			avg_next = `AVG_RST;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			mode_reg <= `MODE_RST;
			ta_reg <= `TIME_A_RST;
			tb_reg <= `TIME_B_RST;
			stup_reg <= `STARTUP_RST;
			ralm_reg <= `RUN_ALARM_RST;
			oalm_reg <= `ON_ALARM_RST;
			avg_reg <= `AVG_RST;
			imask_reg <= 5'h0;
		end else begin
			mode_reg <= mode_next;
			ta_reg <= ta_next;
			tb_reg <= tb_next;
			stup_reg <= stup_next;
			ralm_reg <= ralm_next;
			oalm_reg <= oalm_next;
			avg_reg <= avg_next;
			imask_reg <= imask_next;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Tacho interval thresholds, single interval regardless of averaging
	pulse_interval #(
		.MS_CYCLES(MS_CYCLES)
	) u_interval (
		.aclk(aclk),
		.aresetn(aresetn),
		.pulse(pulse_tick && started_reg),
		.time_a(ta_reg),
		.time_b(tb_reg),
		.a_over(a_over),
		.b_over(b_over)
	);

	// Timebase, accumulators, faults, output, display and interrupts
	always_comb begin
		tcnt_next = tenth_tick ? 32'h0 : tcnt_reg + 32'h1;
		bcnt_next = bcnt_reg;
		blink_next = blink_reg;
		scnt_next = scnt_reg;
		ysec_next = ysec_reg;
		run_next = run_reg;
		scount_next = scount_reg;
		started_next = started_reg || scount_reg >= stup_reg;
		if (tenth_tick) begin
			bcnt_next = bcnt_reg + 3'h1;
			if (bcnt_reg == `BLINK_HALF_TENTHS) begin
				bcnt_next = 3'h0;
				blink_next = !blink_reg;
			end
			if (!started_reg)
				scount_next = scount_reg + 10'h1;
			scnt_next = scnt_reg + 4'h1;
			if (scnt_reg == `TENTHS_PER_SEC) begin
				scnt_next = 4'h0;
				ysec_next = ysec_reg + 32'h1;
				if (ysec_reg >= TENTH_YEAR_SEC - 1) begin
					ysec_next = 32'h0;
					if (run_reg != 10'h3ff)
						run_next = run_reg + 10'h1;
				end
			end
		end
		// Faults: clear first, so a fault in the clearing cycle wins
		fault_next = fault_reg;
		if (hold_op && (fault_reg == tacho_diag_pkg::F_CPU ||
			fault_reg == tacho_diag_pkg::F_NVM))
			fault_next = tacho_diag_pkg::F_NONE;
		if (ram_fault)
			fault_next = tacho_diag_pkg::F_RAM;
		else if (fault_reg != tacho_diag_pkg::F_RAM) begin
			if (nvm_fault)
				fault_next = tacho_diag_pkg::F_NVM;
			else if (cpu_fault && fault_next == tacho_diag_pkg::F_NONE)
				fault_next = tacho_diag_pkg::F_CPU;
		end
		rpl_clr_next = rpl_clr_reg || (hold_op && rpl_show);
		// Output; a hold operation is deliberately not an input here
		out_next = out_reg;
		if (fault_reg != tacho_diag_pkg::F_NONE)
			out_next = 1'b0;
		else if (!started_reg)
			out_next = 1'b0;
		else if (hold_in || ovf)
			out_next = out_reg;
		else if (mode_reg == tacho_diag_pkg::OM_UPPER_LOWER) begin
			if (ta_reg >= tb_reg)
				out_next = 1'b1;
			else
				out_next = a_over && !b_over;
		end else if (b_over)
			out_next = 1'b0;
		else if (a_over)
			out_next = 1'b1;
		// Output ON count, thousands with a sub-counter
		onsub_next = onsub_reg;
		onk_next = onk_reg;
		if (out_next && !out_reg) begin
			onsub_next = onsub_reg + 10'h1;
			if (onsub_reg == `ON_SUB_MAX) begin
				onsub_next = 10'h0;
				if (onk_reg != 14'h3fff)
					onk_next = onk_reg + 14'h1;
			end
		end
		// Display selection by priority
		dv_next = hold_in ? dv_reg : meas_value;
		sd_next = tacho_diag_pkg::SD_NORMAL;
		md_next = tacho_diag_pkg::MD_VALUE;
		if (fault_reg == tacho_diag_pkg::F_RAM) begin
			md_next = tacho_diag_pkg::MD_MEMORY;
			sd_next = tacho_diag_pkg::SD_BLANK;
		end else if (fault_reg == tacho_diag_pkg::F_NVM) begin
			md_next = tacho_diag_pkg::MD_MEMORY;
			sd_next = tacho_diag_pkg::SD_CHECKSUM;
		end else if (fault_reg == tacho_diag_pkg::F_CPU) begin
			md_next = tacho_diag_pkg::MD_CPU;
			sd_next = tacho_diag_pkg::SD_BLANK;
		end else if (ovf)
			md_next = blink_reg ? tacho_diag_pkg::MD_OVERFLOW
				: tacho_diag_pkg::MD_BLANK;
		else if (rpl_show && blink_reg)
			md_next = tacho_diag_pkg::MD_REPLACE;
		// Sticky status, write one to clear, set wins
		ist_next = ist_reg;
		if (wr_go && waddr_reg == `ADDR_IRQ_STAT)
			ist_next = ist_reg & ~ctrl_w[4:0];
		ist_next = ist_next | events;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			tcnt_reg <= 32'h0;
			bcnt_reg <= 3'h0;
			blink_reg <= 1'b0;
			scnt_reg <= 4'h0;
			ysec_reg <= 32'h0;
			run_reg <= 10'h0;
			scount_reg <= 10'h0;
			started_reg <= 1'b0;
			fault_reg <= tacho_diag_pkg::F_NONE;
			rpl_clr_reg <= 1'b0;
			out_reg <= 1'b0;
			onsub_reg <= 10'h0;
			onk_reg <= 14'h0;
			dv_reg <= 20'h0;
			sd_reg <= tacho_diag_pkg::SD_NORMAL;
			md_reg <= tacho_diag_pkg::MD_VALUE;
			ist_reg <= 5'h0;
			ovf_prev_reg <= 1'b0;
			rpl_prev_reg <= 1'b0;
		end else begin
			tcnt_reg <= tcnt_next;
			bcnt_reg <= bcnt_next;
			blink_reg <= blink_next;
			scnt_reg <= scnt_next;
			ysec_reg <= ysec_next;
			run_reg <= run_next;
			scount_reg <= scount_next;
			started_reg <= started_next;
			fault_reg <= fault_next;
			rpl_clr_reg <= rpl_clr_next;
			out_reg <= out_next;
			onsub_reg <= onsub_next;
			onk_reg <= onk_next;
			dv_reg <= dv_next;
			sd_reg <= sd_next;
			md_reg <= md_next;
			ist_reg <= ist_next;
			ovf_prev_reg <= ovf;
			rpl_prev_reg <= rpl_show;
		end
	end

	assign out_on = out_reg;
	assign main_disp = md_reg;
	assign sub_disp = sd_reg;
	assign disp_value = dv_reg;
	assign irq = |(ist_reg & imask_reg);
endmodule : tacho_self_diag_hold

/* File: tb/sensor_panel_model.sv */
module sensor_panel_model (
	input wire logic aclk,
	input wire logic run,
	input wire logic [7:0] gap,
	input wire logic key_req,
	input wire logic hold_req,
	output logic pulse_tick = 1'b0,
	output logic hold_in = 1'b0,
	output logic hold_key = 1'b0
);
	timeunit 1ns;
	timeprecision 1ps;
	int cnt = 0;
	logic key_seen = 1'b0;
	// Sensor pulse every gap plus one cycles while running
	always @(posedge aclk) begin
		cnt <= (run && cnt < gap) ? cnt + 1 : 0;
		pulse_tick <= run && cnt == gap;
	end
	// One key pulse per press; hold level kept as long as asked
	always @(posedge aclk) begin
		key_seen <= key_req;
		hold_key <= key_req && !key_seen;
		hold_in <= hold_req;
	end
endmodule : sensor_panel_model

/* File: tb/tacho_diag_properties.sv */
module tacho_diag_checker (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic awvalid,
	input wire logic awready,
	input wire logic wvalid,
	input wire logic wready,
	input wire logic bvalid,
	input wire logic arvalid,
	input wire logic arready,
	input wire logic rvalid,
	input wire logic hold_in,
	input wire logic [19:0] meas_value,
	input wire logic cpu_fault,
	input wire logic ram_fault,
	input wire logic nvm_fault,
	input wire logic out_on,
	input wire logic [2:0] main_disp,
	input wire logic [1:0] sub_disp,
	input wire logic [19:0] disp_value
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// Any fault event, one cycle wide
	wire logic fault_any;
	assign fault_any = cpu_fault | ram_fault | nvm_fault;
	// Steady overflow with no fault shown
	sequence s_over3;
		(meas_value > 20'hf423f && sub_disp == 2'h0)[*3];
	endsequence
	// Steady hold input with no fault shown
	sequence s_hold3;
		(hold_in && sub_disp == 2'h0)[*3];
	endsequence
	////////////////////////////////////////
	a_fault_out_off: assert property (
		fault_any |-> ##2 !out_on)
		else $error("fault left the output on");
	a_ram_disp: assert property (ram_fault |->
		##2 (main_disp == 3'h4 && sub_disp == 2'h1))
		else $error("memory fault display wrong");
	a_ram_sticky: assert property (ram_fault ##2 1 |->
		(!out_on && sub_disp == 2'h1)[*8])
		else $error("memory fault cleared early");
	a_nvm_tag: assert property (
		nvm_fault && sub_disp != 2'h1 |->
		##2 (sub_disp == 2'h2 && main_disp == 3'h4))
		else $error("checksum fault display wrong");
	a_cpu_blank: assert property (
		cpu_fault && sub_disp == 2'h0 |->
		##2 (sub_disp == 2'h1 && main_disp == 3'h3))
		else $error("processor fault display wrong");
	a_over_flash: assert property (s_over3 |->
		main_disp == 3'h1 || main_disp == 3'h2)
		else $error("overflow pattern missing");
	a_over_out_kept: assert property (
		s_over3 |-> $stable(out_on))
		else $error("output moved during overflow");
	a_hold_frozen: assert property (s_hold3 |->
		$stable(disp_value) && $stable(out_on))
		else $error("hold did not freeze value and output");
	a_read_answer: assert property (arvalid && arready |=> rvalid)
		else $error("read answer late");
	a_write_answer: assert property (awvalid && awready && wvalid &&
		wready |-> ##2 bvalid)
		else $error("write answer late");
endmodule : tacho_diag_checker

/* File: tb/tacho_self_diag_hold_tb.sv */
module tacho_self_diag_hold_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic aclk = 1'b0, aresetn = 1'b0;
	logic [7:0] awaddr = 8'h00, araddr = 8'h00, gap = 8'h0c;
	logic [31:0] wdata = 32'h0, rdata;
	logic [3:0] wstrb = 4'hf;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
	logic arvalid = 1'b0, rready = 1'b0, run = 1'b0;
	logic cpu_fault = 1'b0, ram_fault = 1'b0, nvm_fault = 1'b0;
	logic key_req = 1'b0, hold_req = 1'b0;
	logic [19:0] meas_value = 20'h0, disp_value;
	logic awready, wready, bvalid, arready, rvalid, irq;
	logic pulse_tick, hold_in, hold_key, out_on;
	logic [1:0] bresp, rresp, sub_disp;
	logic [2:0] main_disp;
	int num_errors = 0, samples_checked = 0;

	// Clock and instances
	always #12.5 aclk = ~aclk;
	tacho_self_diag_hold #(.TENTH_SEC_CYCLES(10), .MS_CYCLES(4),
		.TENTH_YEAR_SEC(2)) dut_u (.aclk, .aresetn, .awaddr, .awvalid,
		.awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid,
		.bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid,
		.rready, .pulse_tick, .hold_in, .hold_key, .meas_value,
		.cpu_fault, .ram_fault, .nvm_fault, .out_on, .main_disp,
		.sub_disp, .disp_value, .irq);
	sensor_panel_model model_u (.aclk, .run, .gap, .key_req,
		.hold_req, .pulse_tick, .hold_in, .hold_key);
	////////////////////////////////////////
	task automatic test_done();
		$display("checks %0d errors %0d", samples_checked, num_errors);
		if (num_errors == 0 && samples_checked > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : test_done
	task automatic chk(input string nm, input logic [31:0] e,
		input logic [31:0] g);
		samples_checked++;
		if (g !== e) begin
			num_errors++;
			$display("MISMATCH %s exp %h got %h", nm, e, g);
		end
	endtask : chk
	task automatic cyc(input int n);
		repeat (n) @(posedge aclk);
		#1;
	endtask : cyc
	// Event selectors for the one-cycle pulse task
	localparam int ev_key = 0, ev_cpu = 1, ev_ram = 2, ev_nvm = 3;
	task automatic zap(input int w);
		@(posedge aclk);
		{nvm_fault, ram_fault, cpu_fault, key_req} <= 4'h1 << w;
		@(posedge aclk);
		{nvm_fault, ram_fault, cpu_fault, key_req} <= 4'h0;
	endtask : zap
	task automatic rst();
		@(posedge aclk);
		aresetn <= 1'b0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
	endtask : rst
	// Bound check that ends the run when a bounded wait has run out
	task automatic lim_hit(input int n);
		if (n >= 50) begin
			num_errors++;
			test_done();
		end
	endtask : lim_hit
	task automatic wr(input logic [7:0] a, input logic [31:0] d,
		input logic [1:0] er);
		int n;
		n = 0;
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (awready === 1'b1) awvalid <= 1'b0;
			if (wready === 1'b1) wvalid <= 1'b0;
			n++;
		end while (bvalid !== 1'b1 && n < 50);
		lim_hit(n);
		chk("bresp", {30'h0, er}, {30'h0, bresp});
		bready <= 1'b0;
	endtask : wr
	task automatic rc(input logic [7:0] a, input logic [31:0] e,
		input logic [1:0] er);
		int n;
		n = 0;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (arready === 1'b1) arvalid <= 1'b0;
			n++;
		end while (rvalid !== 1'b1 && n < 50);
		lim_hit(n);
		chk("rdata", e, rdata);
		chk("rresp", {30'h0, er}, {30'h0, rresp});
		rready <= 1'b0;
	endtask : rc
	task automatic wt(input logic s, input logic [2:0] v, input int lim);
		int n;
		n = 0;
		while ((s ? main_disp : {2'b00, out_on}) !== v && n < lim) begin
			@(posedge aclk);
			n++;
		end
		chk(s ? "main_disp" : "out_on", v, s ? main_disp : out_on);
		if ((s ? main_disp : {2'b00, out_on}) !== v)
			test_done();
	endtask : wt
	task automatic nosee(input int lim);
		int k;
		k = 0;
		repeat (lim) begin
			@(posedge aclk);
			if (main_disp === 3'h5) k++;
		end
		chk("replace_hits", 0, k);
	endtask : nosee
	////////////////////////////////////////
	// Main sequence
	initial begin
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		rc(8'h04, 32'h3e8, 2'h0);
		rc(8'h40, 32'h0, 2'h2);
		wr(8'h1c, 32'h1, 2'h2);
		wr(8'h10, 32'h3e8, 2'h0);
		rc(8'h10, 32'h64, 2'h0);
		wr(8'h0c, 32'h3e7, 2'h0);
		rc(8'h0c, 32'h3e7, 2'h0);
		wr(8'h0c, 32'h0, 2'h0);
		wr(8'h04, 32'h2, 2'h0);
		wr(8'h08, 32'h5, 2'h0);
		wr(8'h18, 32'h8, 2'h0);
		run <= 1'b1;
		// Waiting for eight averaged intervals would overrun this bound
		wt(1'b0, 3'h1, 40);
		meas_value <= 20'h00123;
		cyc(40);
		chk("out_on", 32'h1, out_on);
		chk("disp_value", 32'h123, disp_value);
		hold_req <= 1'b1;
		cyc(3);
		meas_value <= 20'h00456;
		run <= 1'b0;
		cyc(60);
		chk("out_on", 32'h1, out_on);
		chk("disp_value", 32'h123, disp_value);
		hold_req <= 1'b0;
		wt(1'b0, 3'h0, 20);
		chk("disp_value", 32'h456, disp_value);
		run <= 1'b1;
		wt(1'b0, 3'h1, 300);
		zap(ev_key);
		cyc(3);
		chk("out_on", 32'h1, out_on);
		wr(8'h00, 32'h1, 2'h0);
		wr(8'h04, 32'h5, 2'h0);
		wr(8'h08, 32'h2, 2'h0);
		run <= 1'b0;
		cyc(80);
		chk("out_on", 32'h1, out_on);
		meas_value <= 20'hf4240;
		wt(1'b1, 3'h1, 120);
		wt(1'b1, 3'h2, 120);
		chk("out_on", 32'h1, out_on);
		wr(8'h24, 32'h2, 2'h0);
		zap(ev_cpu);
		cyc(2);
		chk("out_on", 32'h0, out_on);
		chk("disp", 32'h0d, {main_disp, sub_disp});
		chk("irq", 32'h1, irq);
		rc(8'h20, 32'h3, 2'h0);
		wr(8'h20, 32'h2, 2'h0);
		chk("irq", 32'h0, irq);
		wr(8'h24, 32'h0, 2'h0);
		zap(ev_cpu);
		cyc(2);
		chk("irq", 32'h0, irq);
		meas_value <= 20'h00123;
		zap(ev_key);
		cyc(3);
		chk("disp", 32'h0, {main_disp, sub_disp});
		rc(8'h04, 32'h5, 2'h0);
		zap(ev_nvm);
		cyc(2);
		chk("disp", 32'h12, {main_disp, sub_disp});
		chk("out_on", 32'h0, out_on);
		zap(ev_key);
		cyc(3);
		chk("sub_disp", 32'h0, sub_disp);
		rc(8'h04, 32'h3e8, 2'h0);
		rc(8'h00, 32'h0, 2'h0);
		meas_value <= 20'hf4240;
		zap(ev_ram);
		cyc(2);
		chk("disp", 32'h11, {main_disp, sub_disp});
		zap(ev_key);
		cyc(3);
		chk("disp", 32'h11, {main_disp, sub_disp});
		meas_value <= 20'h00123;
		rst();
		cyc(1);
		chk("disp", 32'h0, {main_disp, sub_disp});
		chk("out_on", 32'h0, out_on);
		wr(8'h10, 32'h1, 2'h0);
		wt(1'b1, 3'h5, 700);
		zap(ev_key);
		// Let the key reach the display before counting replace frames
		cyc(3);
		nosee(300);
		// Run time has passed two tenth-years by now and keeps counting
		rc(8'h28, 32'h2, 2'h0);
		rst();
		wr(8'h10, 32'h1, 2'h0);
		wt(1'b1, 3'h5, 700);
		rst();
		wr(8'h10, 32'h0, 2'h0);
		nosee(500);
		test_done();
	end
endmodule : tacho_self_diag_hold_tb

bind tacho_self_diag_hold tacho_diag_checker chk_u (.aclk, .aresetn,
	.awvalid, .awready, .wvalid, .wready, .bvalid, .arvalid, .arready,
	.rvalid, .hold_in, .meas_value, .cpu_fault, .ram_fault, .nvm_fault,
	.out_on, .main_disp, .sub_disp, .disp_value);
